/* File: cpw_pkg.sv */
package cpw_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_STAGING    = 8'h04;
    localparam logic [7:0] ADDR_PERIOD     = 8'h08;
    localparam logic [7:0] ADDR_TIMEBASE   = 8'h0c;
    localparam logic [7:0] ADDR_SHADOW     = 8'h10;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h14;
    // control register fields
    localparam int CTRL_LSB_HI   = 5;
    localparam int CTRL_LSB_LO   = 4;
    localparam int CTRL_MODE_HI  = 3;
    localparam int CTRL_MODE_LO  = 0;
    localparam logic [3:0] MODE_PWM = 4'hc;
    // timer control fields
    localparam int TCTL_PRE_HI   = 1;
    localparam int TCTL_PRE_LO   = 0;
    localparam int TCTL_ON_BIT   = 2;
    localparam int TCTL_POST_HI  = 6;
    localparam int TCTL_POST_LO  = 3;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [9:0] ZERO10       = 10'h000;
    // oscillator periods per timebase increment
    localparam int OSC_PER_INC  = 4;
    localparam int SUB_BITS     = 2;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* File: cpw_pwm.sv */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Operation
// - pwm waveform on output pin, up to ten bit duty resolution
// - all-zero control write forces dedicated output latch low
// - period is (period+1) times 4 clocks times prescale
// - counter equal to period clears on next increment
// - output set at period match unless duty is zero
// - staging duty copied into shadow at period match
// - postscaler does not affect pwm frequency
// - duty is staging as high eight, control bits 5:4 low two
// - high time is duty times one clock times prescale
// - duty writes anytime, take effect only at next period match
// - shadow is read-only in pwm mode
module cpw_pwm #(
    parameter int PRESCALE_W = 4
) (
    input  wire logic        ref_clk,      // 25 MHz clock, one oscillator period
    input  wire logic        sys_rst,      // async reset, active high
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    output logic             pwm_output_pin, // pwm waveform
    output logic             postscale_evt // slow update event pulse
);
    // refuse a prescale count too narrow for the divide by 64
    if (PRESCALE_W < 4) begin : g_width_check
        $error("prescale width too small");
    end

    logic [7:0] capture_compare_control_reg;
    logic [7:0] duty_staging_register_reg;
    logic [9:0] duty_latched_shadow_reg;
    logic [7:0] period_register_reg;
    logic [7:0] timebase_counter_reg;
    logic [7:0] timer_ctrl_reg;
    logic [PRESCALE_W+1:0] osc_count_reg;  // sub-count plus prescale count
    logic [3:0] post_count_reg;
    logic       pwm_pin_output_latch_reg;
    logic       wr_en;
    logic       mapped;
    logic       pwm_mode;
    logic       timer_on;
    logic [PRESCALE_W+1:0] inc_limit;
    logic       inc_tick;
    logic       match;
    logic       period_tick;
    logic [9:0] duty_staged;
    logic [9:0] fine_count;
    logic [1:0] sub_count;
    logic       fine_step;
    logic [9:0] fine_next;

    // apb decode; answers in the access cycle
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == cpw_pkg::ADDR_CONTROL) || (paddr == cpw_pkg::ADDR_STAGING)
                  || (paddr == cpw_pkg::ADDR_PERIOD) || (paddr == cpw_pkg::ADDR_TIMEBASE)
                  || (paddr == cpw_pkg::ADDR_SHADOW) || (paddr == cpw_pkg::ADDR_TIMER_CTRL);
    assign pslverr = psel && penable && !mapped;

    assign pwm_mode = capture_compare_control_reg[cpw_pkg::CTRL_MODE_HI:cpw_pkg::CTRL_MODE_LO]
                      == cpw_pkg::MODE_PWM;
    assign timer_on = timer_ctrl_reg[cpw_pkg::TCTL_ON_BIT];
    // prescale 1,4,16 (and 16 again for code 3) times 4 clocks per increment
    always_comb begin
        case (timer_ctrl_reg[cpw_pkg::TCTL_PRE_HI:cpw_pkg::TCTL_PRE_LO])
            2'h0:    inc_limit = (PRESCALE_W+2)'(cpw_pkg::OSC_PER_INC - 1);
            2'h1:    inc_limit = (PRESCALE_W+2)'(cpw_pkg::OSC_PER_INC * 4 - 1);
            default: inc_limit = (PRESCALE_W+2)'(cpw_pkg::OSC_PER_INC * 16 - 1);
        endcase
    end
    assign inc_tick    = timer_on && (osc_count_reg >= inc_limit);
    assign match       = timebase_counter_reg == period_register_reg;
    assign period_tick = inc_tick && match;
    // ten bit duty: staging high, control 5:4 low
    assign duty_staged = {duty_staging_register_reg,
                          capture_compare_control_reg[cpw_pkg::CTRL_LSB_HI:cpw_pkg::CTRL_LSB_LO]};
    // sub-count and the clock in which the ten bit count steps on;
    // the pin drops on the step into the duty count, so it is high
    // for exactly duty times prescale clocks, not one clock more
    always_comb begin
        case (timer_ctrl_reg[cpw_pkg::TCTL_PRE_HI:cpw_pkg::TCTL_PRE_LO])
            2'h0: begin
                sub_count = osc_count_reg[1:0];
                fine_step = timer_on;
            end
            2'h1: begin
                sub_count = osc_count_reg[3:2];
                fine_step = timer_on && (osc_count_reg[1:0] == 2'h3);
            end
            default: begin
                sub_count = osc_count_reg[5:4];
                fine_step = timer_on && (osc_count_reg[3:0] == 4'hf);
            end
        endcase
    end
    assign fine_count = {timebase_counter_reg, sub_count};
    assign fine_next  = fine_count + 10'h001;

    // register writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            capture_compare_control_reg <= cpw_pkg::CTRL_RESET;
            duty_staging_register_reg   <= cpw_pkg::ZERO8;
            period_register_reg         <= cpw_pkg::PERIOD_RESET;
            timer_ctrl_reg              <= cpw_pkg::ZERO8;
        end else if (wr_en) begin
            case (paddr)
                cpw_pkg::ADDR_CONTROL:    capture_compare_control_reg <= pwdata[7:0];
                cpw_pkg::ADDR_STAGING:    duty_staging_register_reg   <= pwdata[7:0];
                cpw_pkg::ADDR_PERIOD:     period_register_reg         <= pwdata[7:0];
                cpw_pkg::ADDR_TIMER_CTRL: timer_ctrl_reg              <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // prescaler and sub-count; timebase counter write clears it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_count_reg <= '0;
        end else if (!timer_on || inc_tick || (wr_en && paddr == cpw_pkg::ADDR_TIMEBASE)) begin
            osc_count_reg <= '0;
        end else begin
            osc_count_reg <= osc_count_reg + 1'b1;
        end
    end

    // timebase counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timebase_counter_reg <= cpw_pkg::ZERO8;
        end else if (wr_en && paddr == cpw_pkg::ADDR_TIMEBASE) begin
            timebase_counter_reg <= pwdata[7:0];
        end else if (period_tick) begin
            timebase_counter_reg <= cpw_pkg::ZERO8;
        end else if (inc_tick) begin
            timebase_counter_reg <= timebase_counter_reg + 8'h01;
        end
    end

    // shadow loads only at period match, never from the bus
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            duty_latched_shadow_reg <= cpw_pkg::ZERO10;
        end else if (period_tick) begin
            duty_latched_shadow_reg <= duty_staged;
        end
    end

    // postscaler counts period matches, separate from pwm timing
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            post_count_reg <= 4'h0;
            postscale_evt  <= 1'b0;
        end else begin
            postscale_evt <= 1'b0;
            if (period_tick) begin
                if (post_count_reg == timer_ctrl_reg[cpw_pkg::TCTL_POST_HI:cpw_pkg::TCTL_POST_LO]) begin
                    post_count_reg <= 4'h0;
                    postscale_evt  <= 1'b1;
                end else begin
                    post_count_reg <= post_count_reg + 4'h1;
                end
            end
        end
    end

    // dedicated output latch
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_pin_output_latch_reg <= 1'b0;
        end else if (wr_en && paddr == cpw_pkg::ADDR_CONTROL && pwdata[7:0] == cpw_pkg::ZERO8) begin
            pwm_pin_output_latch_reg <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_pin_output_latch_reg <= 1'b0;
        end else if (period_tick) begin
            pwm_pin_output_latch_reg <= (duty_staged != cpw_pkg::ZERO10);
        end else if (fine_step && fine_next == duty_latched_shadow_reg) begin
            pwm_pin_output_latch_reg <= 1'b0;
        end
    end
    assign pwm_output_pin = pwm_pin_output_latch_reg;

    // read mux
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= cpw_pkg::UNMAPPED_DATA;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                cpw_pkg::ADDR_CONTROL:    prdata <= {24'h0, capture_compare_control_reg};
                cpw_pkg::ADDR_STAGING:    prdata <= {24'h0, duty_staging_register_reg};
                cpw_pkg::ADDR_PERIOD:     prdata <= {24'h0, period_register_reg};
                cpw_pkg::ADDR_TIMEBASE:   prdata <= {24'h0, timebase_counter_reg};
                cpw_pkg::ADDR_SHADOW:     prdata <= {22'h0, duty_latched_shadow_reg};
                cpw_pkg::ADDR_TIMER_CTRL: prdata <= {24'h0, timer_ctrl_reg};
                default:                  prdata <= cpw_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    // counter clears to zero on a match increment
    property p_clear_after_match;
        @(posedge ref_clk) disable iff (sys_rst)
        period_tick && !(wr_en && paddr == cpw_pkg::ADDR_TIMEBASE) |=> timebase_counter_reg == 8'h00;
    endproperty
    a_clear_after_match: assert property (p_clear_after_match) else $error("no clear");

    property p_set_on_match;
        @(posedge ref_clk) disable iff (sys_rst)
        period_tick && pwm_mode && duty_staged != 10'h000 && !wr_en |=> pwm_output_pin;
    endproperty
    a_set_on_match: assert property (p_set_on_match) else $error("pin not set");

    property p_zero_duty;
        @(posedge ref_clk) disable iff (sys_rst)
        period_tick && duty_staged == 10'h000 |=> !pwm_output_pin;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty set pin");

    property p_shadow_load;
        @(posedge ref_clk) disable iff (sys_rst)
        period_tick |=> duty_latched_shadow_reg == $past(duty_staged);
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

    property p_shadow_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        !period_tick |=> $stable(duty_latched_shadow_reg);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved");

    property p_zero_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && paddr == cpw_pkg::ADDR_CONTROL && pwdata[7:0] == 8'h00 |=> !pwm_output_pin;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("latch not cleared");

    property p_fall_on_duty;
        @(posedge ref_clk) disable iff (sys_rst)
        pwm_mode && !period_tick && !wr_en && fine_step && fine_next == duty_latched_shadow_reg
            |=> !pwm_output_pin;
    endproperty
    a_fall_on_duty: assert property (p_fall_on_duty) else $error("no fall");

    property p_inc_spacing;
        @(posedge ref_clk) disable iff (sys_rst)
        inc_tick && timer_ctrl_reg[1:0] == 2'h0 && !wr_en ##1 !wr_en[*3] |-> ##1 inc_tick;
    endproperty
    a_inc_spacing: assert property (p_inc_spacing) else $error("bad prescale");

    property p_post_event;
        @(posedge ref_clk) disable iff (sys_rst)
        postscale_evt |-> $past(period_tick);
    endproperty
    a_post_event: assert property (p_post_event) else $error("stray event");

    // pin stays low outside pwm mode
    property p_off_mode_low;
        @(posedge ref_clk) disable iff (sys_rst)
        !pwm_mode |=> !pwm_output_pin;
    endproperty
    a_off_mode_low: assert property (p_off_mode_low) else $error("pin high off mode");

    // shadow ignores bus writes
    property p_shadow_ro;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && paddr == cpw_pkg::ADDR_SHADOW && !period_tick
            |=> $stable(duty_latched_shadow_reg);
    endproperty
    a_shadow_ro: assert property (p_shadow_ro) else $error("shadow written");

    // staging takes bus data at any time
    property p_staging_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && paddr == cpw_pkg::ADDR_STAGING
            |=> duty_staging_register_reg == $past(pwdata[7:0]);
    endproperty
    a_staging_write: assert property (p_staging_write) else $error("staging lost");

    // period register takes bus data
    property p_period_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && paddr == cpw_pkg::ADDR_PERIOD |=> period_register_reg == $past(pwdata[7:0]);
    endproperty
    a_period_write: assert property (p_period_write) else $error("period lost");

    // over-long duty never drops the pin inside a period
    property p_long_duty;
        @(posedge ref_clk) disable iff (sys_rst)
        pwm_mode && pwm_output_pin && !wr_en && !period_tick
            && timebase_counter_reg <= period_register_reg
            && duty_latched_shadow_reg > {period_register_reg, 2'h3} |=> pwm_output_pin;
    endproperty
    a_long_duty: assert property (p_long_duty) else $error("long duty fell");

    // pin rises only at a period match
    property p_rise_at_match;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(pwm_output_pin) |-> $past(period_tick);
    endproperty
    a_rise_at_match: assert property (p_rise_at_match) else $error("stray rise");
endmodule

/* File: cpw_load.sv */
`timescale 1ns/1ps
// external load on the pwm pin, measures its high time and period in clocks
module cpw_load (
    input  wire logic        ref_clk,     // system clock
    input  wire logic        pin,         // pwm pin as seen by the load
    output logic      [15:0] last_high,   // cycles of last high phase
    output logic      [15:0] last_period, // cycles between last two rises
    output logic      [15:0] rises,       // rising edges seen
    output logic      [15:0] falls        // falling edges seen
);
    logic        prev;
    logic [15:0] hcnt;
    logic [15:0] pcnt;
    initial begin
        {prev, hcnt, pcnt, last_high, last_period, rises, falls} = '0;
    end
    // pin is an output toward the load
    always_ff @(posedge ref_clk) begin
        prev <= pin;
        pcnt <= (pin && !prev) ? 16'h0001 : pcnt + 16'h0001;
        hcnt <= (pin && !prev) ? 16'h0001 : hcnt + 16'h0001;
        if (pin && !prev) begin
            last_period <= pcnt;
            rises       <= rises + 16'h0001;
        end
        if (!pin && prev) begin
            last_high <= hcnt;
            falls     <= falls + 16'h0001;
        end
    end
endmodule

/* File: test_ccp_pwm_mode_timebase.sv */
`timescale 1ns/1ps
module test_ccp_pwm_mode_timebase;
    logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, pin, evt, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] last_high, last_period, rises, falls, snap;
    int          errors, compares, cycles, n;

    cpw_pwm u_cpw_pwm (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_output_pin(pin), .postscale_evt(evt));
    cpw_load u_cpw_load (.ref_clk(ref_clk), .pin(pin), .last_high(last_high),
        .last_period(last_period), .rises(rises), .falls(falls));

    // clock, 40 ns period
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, setup then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic t_defaults();
        apb(0, cpw_pkg::ADDR_PERIOD, 0);   check(rd, 32'h0000_00ff);
        apb(0, cpw_pkg::ADDR_CONTROL, 0);  check(rd, 32'h0);
        apb(1, 8'h20, 32'h0000_00aa);      check({31'h0, err}, 32'h1);
        apb(0, 8'h20, 0);                  check(rd, cpw_pkg::UNMAPPED_DATA);
        apb(1, cpw_pkg::ADDR_SHADOW, 32'h0000_03ff);
        apb(0, cpw_pkg::ADDR_SHADOW, 0);   check(rd, 32'h0);
    endtask

    // period 3 at prescale 1 is 16 clocks, duty {01,10} is 6 clocks
    task automatic t_basic();
        apb(1, cpw_pkg::ADDR_PERIOD, 32'h3);
        apb(1, cpw_pkg::ADDR_STAGING, 32'h1);
        apb(1, cpw_pkg::ADDR_CONTROL, 32'h2c);
        apb(1, cpw_pkg::ADDR_TIMER_CTRL, 32'h04);
        repeat (64) @(posedge ref_clk);
        check({16'h0, last_period}, 32'd16);
        check({16'h0, last_high}, 32'd6);
        apb(1, cpw_pkg::ADDR_SHADOW, 32'h0);
        apb(0, cpw_pkg::ADDR_SHADOW, 0);   check(rd, 32'd6);
    endtask

    // staging written in the high phase must not touch this period
    task automatic t_change();
        n = 0;
        do @(posedge ref_clk); while (pin !== 1'b1 && ++n < 100);
        apb(1, cpw_pkg::ADDR_STAGING, 32'h2);
        snap = falls;
        repeat (8) @(posedge ref_clk);
        check({16'h0, falls}, {16'h0, snap + 16'h0001});
        check({16'h0, last_high}, 32'd6);
        repeat (40) @(posedge ref_clk);
        check({16'h0, last_high}, 32'd10);
    endtask

    // postscale 1 gives an event every second match, pwm period unchanged
    task automatic t_post();
        apb(1, cpw_pkg::ADDR_TIMER_CTRL, 32'h0c);
        n = 0;
        do @(posedge ref_clk); while (evt !== 1'b1 && ++n < 200);
        n = 0;
        do @(posedge ref_clk); while (evt !== 1'b1 && ++n < 200);
        check(n, 32'd31);
        check({16'h0, last_period}, 32'd16);
    endtask

    // prescale 4: period 64 clocks, high 40; prescale 16: period 256, high 160
    task automatic t_prescale();
        apb(1, cpw_pkg::ADDR_TIMER_CTRL, 32'h05);
        repeat (200) @(posedge ref_clk);
        check({16'h0, last_period}, 32'd64);
        check({16'h0, last_high}, 32'd40);
        apb(1, cpw_pkg::ADDR_TIMER_CTRL, 32'h06);
        repeat (720) @(posedge ref_clk);
        check({16'h0, last_period}, 32'd256);
        check({16'h0, last_high}, 32'd160);
        apb(1, cpw_pkg::ADDR_TIMER_CTRL, 32'h04);
    endtask

    task automatic t_limits();
        apb(1, cpw_pkg::ADDR_STAGING, 32'h0);
        apb(1, cpw_pkg::ADDR_CONTROL, 32'h0c);
        repeat (40) @(posedge ref_clk);
        snap = rises;
        repeat (64) @(posedge ref_clk);
        check({16'h0, rises}, {16'h0, snap});
        apb(1, cpw_pkg::ADDR_STAGING, 32'hff);
        repeat (40) @(posedge ref_clk);
        snap = falls;
        repeat (64) @(posedge ref_clk);
        check({16'h0, falls}, {16'h0, snap});
        check({31'h0, pin}, 32'h1);
        apb(1, cpw_pkg::ADDR_CONTROL, 32'h0);
        @(posedge ref_clk);
        check({31'h0, pin}, 32'h0);
        snap = rises;
        repeat (40) @(posedge ref_clk);
        check({16'h0, rises}, {16'h0, snap});
    endtask

    initial begin
        {errors, compares, cycles} = '0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_basic();
        t_change();
        t_post();
        t_prescale();
        t_limits();
        results();
    end
endmodule
